// file: hw/rxscr_pkg.sv
// rxscr_pkg: constants of the rx status and calibration register bank
package rxscr_pkg;
   // ==========================================================
   // register addresses
   localparam logic [6:0] RXSCR_ADDR_SNAP   = 7'h2E;
   localparam logic [6:0] RXSCR_ADDR_FCAL   = 7'h2F;
   localparam logic [6:0] RXSCR_ADDR_QCAL   = 7'h30;
   localparam logic [6:0] RXSCR_ADDR_SYNTH  = 7'h31;
   // other receiver status registers that also trigger a sample
   localparam logic [6:0] RXSCR_ADDR_MONST  = 7'h37;
   localparam logic [6:0] RXSCR_ADDR_MONERR = 7'h38;
   localparam logic [6:0] RXSCR_ADDR_RSSI   = 7'h39;
   // ==========================================================
   // field positions
   localparam int RXSCR_GAIN_BIT  = 7;
   localparam int RXSCR_LIVE_BIT  = 6;
   localparam int RXSCR_CMD_LSB   = 4;
   localparam int RXSCR_CNT_LSB   = 0;
   localparam int RXSCR_QRUN_BIT  = 7;
   localparam int RXSCR_RCRUN_BIT = 6;
   localparam int RXSCR_RCRES_LSB = 0;
   localparam int RXSCR_TRIG_BIT  = 7;
   localparam int RXSCR_QVAL_LSB  = 0;
   localparam int RXSCR_VCO_BIT   = 7;
   localparam int RXSCR_PFD_BIT   = 6;
   localparam int RXSCR_FAST_BIT  = 5;
   localparam int RXSCR_ICP_LSB   = 0;
   // ==========================================================
   // reset values
   localparam logic [7:0] RXSCR_SYNTH_RST = 8'h04;
   localparam logic [6:0] RXSCR_QVAL_RST  = 7'h00;
   localparam logic [3:0] RXSCR_SNAP_RST  = 4'h0;
   // ==========================================================
   // serial frame
   localparam logic [4:0] RXSCR_ADDR_BITS  = 5'h08;
   localparam logic [4:0] RXSCR_FRAME_BITS = 5'h10;
   // ==========================================================
   // analogue settings and timing
   localparam logic [8:0]  RXSCR_ICP_STEP_UA = 9'h00F;
   localparam logic [11:0] RXSCR_PFD_SHORT_PS = 12'h834;
   localparam logic [11:0] RXSCR_PFD_LONG_PS  = 12'hC1C;
   localparam int RXSCR_CLK_NS        = 100;
   localparam int RXSCR_SETTLE_LONG_NS  = 5000;
   localparam int RXSCR_SETTLE_SHORT_NS = 1000;
   localparam logic [7:0] RXSCR_SETTLE_LONG =
      8'((RXSCR_SETTLE_LONG_NS + RXSCR_CLK_NS - 1) / RXSCR_CLK_NS);
   localparam logic [7:0] RXSCR_SETTLE_SHORT =
      8'((RXSCR_SETTLE_SHORT_NS + RXSCR_CLK_NS - 1) / RXSCR_CLK_NS);
endpackage

// file: hw/rxscr_regs.sv
// rxscr_regs: rx snapshot, calibration and synth override registers
`timescale 1ns/1ps
// What this block does
// - status bit 7 shows high gain selected
// - automatic capture clears read-triggered flag
// - host status read capture sets flag
// - bits 5:4 hold receive sub-command
// - bits 3:0 hold chip transition count
// - calibration status bit 7 marks quadrature run
// - calibration status bit 6 marks RC run
// - writing trigger bit starts quadrature calibration
// - lower band sets low oscillator drive bit
// - long bit widens detector reset to 3.1ns
// - fast bit zero gives long settle delay
// - fast bit one gives short settle delay
// - charge pump current is code times 15uA
module rxscr_regs
   import rxscr_pkg::*;
(
   input  wire logic       core_clk_in,
   input  wire logic       reset_in,
   input  wire logic       ser_enable_in,
   input  wire logic       ser_clk_in,
   input  wire logic       ser_data_in,
   output logic            ser_data_out,
   output logic            ser_data_oe_n_out,
   input  wire logic       rx_high_gain_in,
   input  wire logic [1:0] rx_sub_cmd_in,
   input  wire logic [3:0] transition_count_in,
   input  wire logic       auto_capture_in,
   input  wire logic       rc_filter_cal_active_in,
   input  wire logic [3:0] rc_filter_cal_result_in,
   input  wire logic       quadrature_cal_done_in,
   input  wire logic [6:0] quadrature_cal_result_in,
   input  wire logic       lower_band_in,
   input  wire logic       filter_transient_in,
   output logic            quadrature_cal_start_out,
   output logic            quadrature_cal_active_out,
   output logic [6:0]      quadrature_cal_value_out,
   output logic            low_oscillator_drive_out,
   output logic            long_detector_reset_pulse_out,
   output logic [11:0]     detector_reset_width_ps_out,
   output logic            fast_filter_settling_out,
   output logic            filter_settled_out,
   output logic [4:0]      charge_pump_current_code_out,
   output logic [8:0]      charge_pump_current_ua_out
);
   import rxscr_pkg::*;

   // =============================================================
   // pin synchronisers
   logic [1:0] en_sync_q;
   logic [2:0] clk_sync_q;
   logic [1:0] din_sync_q;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         en_sync_q  <= 2'h0;
         clk_sync_q <= 3'h0;
         din_sync_q <= 2'h0;
      end else begin
         en_sync_q  <= {en_sync_q[0], ser_enable_in};
         clk_sync_q <= {clk_sync_q[1:0], ser_clk_in};
         din_sync_q <= {din_sync_q[0], ser_data_in};
      end
   end

   logic en_s;
   logic rise_s;
   logic fall_s;
   assign en_s   = en_sync_q[1];
   assign rise_s = en_s && clk_sync_q[1] && !clk_sync_q[2];
   assign fall_s = en_s && !clk_sync_q[1] && clk_sync_q[2];

   // =============================================================
   // serial frame: rw bit, 7 address bits, 8 data bits, msb first
   logic [4:0] bit_cnt_q;
   logic [7:0] rx_sh_q;
   logic       rd_q;
   logic [6:0] addr_q;
   logic       addr_done;
   logic       wr_done;

   assign addr_done = rise_s && (bit_cnt_q == RXSCR_ADDR_BITS - 5'h01);
   assign wr_done   = rise_s && !rd_q &&
                      (bit_cnt_q == RXSCR_FRAME_BITS - 5'h01);

   always_ff @(posedge core_clk_in) begin
      if (reset_in || !en_s) begin
         bit_cnt_q <= 5'h00;
         rx_sh_q   <= 8'h00;
         rd_q      <= 1'b0;
         addr_q    <= 7'h00;
      end else if (rise_s) begin
         rx_sh_q <= {rx_sh_q[6:0], din_sync_q[1]};
         if (bit_cnt_q != RXSCR_FRAME_BITS)
            bit_cnt_q <= bit_cnt_q + 5'h01;
         if (bit_cnt_q == 5'h00)
            rd_q <= din_sync_q[1];
         if (addr_done)
            addr_q <= {rx_sh_q[5:0], din_sync_q[1]};
      end
   end

   logic [6:0] cur_addr;
   logic [7:0] wr_byte;
   assign cur_addr = {rx_sh_q[5:0], din_sync_q[1]};
   assign wr_byte  = {rx_sh_q[6:0], din_sync_q[1]};

   logic rd_trig;
   assign rd_trig = addr_done && rd_q &&
                    (cur_addr == RXSCR_ADDR_SNAP   ||
                     cur_addr == RXSCR_ADDR_MONST  ||
                     cur_addr == RXSCR_ADDR_MONERR ||
                     cur_addr == RXSCR_ADDR_RSSI);

   // =============================================================
   // receiver snapshot
   logic       live_q;
   logic [1:0] cmd_q;
   logic [3:0] cnt_q;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         live_q <= 1'b0;
         cmd_q  <= 2'h0;
         cnt_q  <= RXSCR_SNAP_RST;
      end else if (auto_capture_in || rd_trig) begin
         live_q <= !auto_capture_in;
         cmd_q  <= rx_sub_cmd_in;
         cnt_q  <= transition_count_in;
      end
   end

   logic [7:0] snap_byte;
   logic [7:0] fcal_byte;
   always_comb begin
      snap_byte = 8'h00;
      snap_byte[RXSCR_GAIN_BIT] = rx_high_gain_in;
      snap_byte[RXSCR_LIVE_BIT] = live_q;
      snap_byte[RXSCR_CMD_LSB +: 2] = cmd_q;
      snap_byte[RXSCR_CNT_LSB +: 4] = cnt_q;
      fcal_byte = 8'h00;
      fcal_byte[RXSCR_QRUN_BIT]  = quadrature_cal_active_out;
      fcal_byte[RXSCR_RCRUN_BIT] = rc_filter_cal_active_in;
      fcal_byte[RXSCR_RCRES_LSB +: 4] = rc_filter_cal_result_in;
   end

   // =============================================================
   // quadrature calibration control
   logic qwr;
   logic qtrig;
   assign qwr   = wr_done && (addr_q == RXSCR_ADDR_QCAL);
   assign qtrig = qwr && wr_byte[RXSCR_TRIG_BIT];

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         quadrature_cal_active_out <= 1'b0;
         quadrature_cal_start_out  <= 1'b0;
      end else begin
         quadrature_cal_start_out <= qtrig;
         if (qtrig)
            quadrature_cal_active_out <= 1'b1;
         else if (quadrature_cal_done_in)
            quadrature_cal_active_out <= 1'b0;
      end
   end

   // host value wins over a result arriving in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (reset_in)
         quadrature_cal_value_out <= RXSCR_QVAL_RST;
      else if (qwr)
         quadrature_cal_value_out <= wr_byte[RXSCR_QVAL_LSB +: 7];
      else if (quadrature_cal_done_in && quadrature_cal_active_out)
         quadrature_cal_value_out <= quadrature_cal_result_in;
   end

   // =============================================================
   // synthesizer tuning overrides
   logic [7:0] synth_q;
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         synth_q <= RXSCR_SYNTH_RST;
      end else begin
         if (wr_done && addr_q == RXSCR_ADDR_SYNTH)
            synth_q <= wr_byte;
         if (lower_band_in)
            synth_q[RXSCR_VCO_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         low_oscillator_drive_out      <= 1'b0;
         long_detector_reset_pulse_out <= 1'b0;
         detector_reset_width_ps_out   <= RXSCR_PFD_SHORT_PS;
         fast_filter_settling_out      <= 1'b0;
         charge_pump_current_code_out  <= 5'h00;
         charge_pump_current_ua_out    <= 9'h000;
      end else begin
         low_oscillator_drive_out <= synth_q[RXSCR_VCO_BIT];
         long_detector_reset_pulse_out <= synth_q[RXSCR_PFD_BIT];
         detector_reset_width_ps_out <= synth_q[RXSCR_PFD_BIT] ?
            RXSCR_PFD_LONG_PS : RXSCR_PFD_SHORT_PS;
         fast_filter_settling_out <= synth_q[RXSCR_FAST_BIT];
         charge_pump_current_code_out <= synth_q[RXSCR_ICP_LSB +: 5];
         charge_pump_current_ua_out <= 9'(
            {4'h0, synth_q[RXSCR_ICP_LSB +: 5]} *
            RXSCR_ICP_STEP_UA);
      end
   end

   // =============================================================
   // channel filter settle timer
   logic [7:0] settle_q;
   always_ff @(posedge core_clk_in) begin
      if (reset_in)
         settle_q <= 8'h00;
      else if (filter_transient_in)
         settle_q <= synth_q[RXSCR_FAST_BIT] ?
            RXSCR_SETTLE_SHORT :
            RXSCR_SETTLE_LONG;
      else if (settle_q != 8'h00)
         settle_q <= settle_q - 8'h01;
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in)
         filter_settled_out <= 1'b1;
      else
         filter_settled_out <= !filter_transient_in &&
                               (settle_q <= 8'h01);
   end

   // =============================================================
   // read data path
   logic       load_q;
   logic [7:0] tx_q;
   logic [7:0] rd_byte;

   always_comb begin
      unique case (addr_q)
         RXSCR_ADDR_SNAP:  rd_byte = snap_byte;
         RXSCR_ADDR_FCAL:  rd_byte = fcal_byte;
         RXSCR_ADDR_QCAL:  rd_byte = {quadrature_cal_active_out,
                                      quadrature_cal_value_out};
         RXSCR_ADDR_SYNTH: rd_byte = synth_q;
         default:          rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in || !en_s) begin
         load_q <= 1'b0;
         tx_q   <= 8'h00;
      end else begin
         load_q <= addr_done && rd_q;
         if (load_q)
            tx_q <= rd_byte;
         else if (fall_s && bit_cnt_q > RXSCR_ADDR_BITS)
            tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         ser_data_out      <= 1'b0;
         ser_data_oe_n_out <= 1'b1;
      end else begin
         ser_data_out      <= tx_q[7];
         ser_data_oe_n_out <= !(en_s && rd_q &&
                               bit_cnt_q >= RXSCR_ADDR_BITS);
      end
   end

   // =============================================================
   // checks
   AST_AUTO_FLAG: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      auto_capture_in |=> !live_q)
      else $error("auto capture left read flag set");
   AST_READ_FLAG: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      rd_trig && !auto_capture_in |=> live_q)
      else $error("status read did not set read flag");
   AST_SUB_CMD: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      (auto_capture_in || rd_trig) |=>
         snap_byte[5:4] == $past(rx_sub_cmd_in))
      else $error("sub-command not captured");
   AST_COUNT: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      (auto_capture_in || rd_trig) |=>
         snap_byte[3:0] == $past(transition_count_in))
      else $error("transition count not captured");
   AST_GAIN: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      addr_q == RXSCR_ADDR_SNAP |-> rd_byte[7] == rx_high_gain_in)
      else $error("gain bit wrong");
   AST_IQ_RUN: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      qtrig |=> fcal_byte[7] && quadrature_cal_start_out)
      else $error("quadrature run flag not raised");
   AST_RC_RUN: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      fcal_byte[6] == rc_filter_cal_active_in)
      else $error("rc run flag wrong");
   AST_START: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      qtrig |=> quadrature_cal_start_out ##1 !quadrature_cal_start_out)
      else $error("start pulse not one cycle long");
   AST_DONE: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      quadrature_cal_done_in && !qtrig |=> !fcal_byte[7])
      else $error("calibration end did not clear flag");
   AST_VCO: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      lower_band_in |=> ##1 low_oscillator_drive_out)
      else $error("low drive not set in lower band");
   AST_PFD: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      long_detector_reset_pulse_out |->
         detector_reset_width_ps_out == RXSCR_PFD_LONG_PS)
      else $error("detector reset width wrong");
   AST_SETTLE: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      filter_transient_in |=> settle_q == ($past(synth_q[5]) ?
         RXSCR_SETTLE_SHORT : RXSCR_SETTLE_LONG) && !filter_settled_out)
      else $error("settle delay wrong");
   AST_ICP: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      charge_pump_current_ua_out ==
         9'({4'h0, charge_pump_current_code_out} * RXSCR_ICP_STEP_UA))
      else $error("charge pump current wrong");
endmodule

// file: verification/rxscr_host_model.sv
// rxscr_host_model: serial host that drives register frames
`timescale 1ns/1ps
module rxscr_host_model (
   input  wire logic core_clk_in,
   input  wire logic line_in,
   output logic      ser_enable_out,
   output logic      ser_clk_out,
   output logic      ser_data_out
);
   // each serial half period spans this many core cycles
   localparam int HALF = 6;
   initial begin
      ser_enable_out = 1'b0;
      ser_clk_out    = 1'b0;
      ser_data_out   = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   // ==========================================================
   // one frame: rw bit, 7 address bits, 8 data bits, msb first
   task automatic xfer(input logic rd, input logic [6:0] addr,
                       input logic [7:0] wdata, output logic [7:0] rdata);
      logic [15:0] frame;
      frame = {rd, addr, wdata};
      rdata = 8'h00;
      wait_clk(1);
      ser_enable_out = 1'b1;
      for (int i = 15; i >= 0; i--) begin
         // released during read data: toggles so stale levels never match
         if (rd && i < 8) ser_data_out = ~ser_data_out;
         else ser_data_out = frame[i];
         wait_clk(HALF);
         ser_clk_out = 1'b1;
         if (rd && i < 8) rdata[i] = line_in;
         wait_clk(HALF);
         ser_clk_out = 1'b0;
      end
      ser_enable_out = 1'b0;
      wait_clk(4);
   endtask
endmodule

// file: verification/testbench.sv
// testbench: self-checking bench for the rx status register bank
`timescale 1ns/1ps
module testbench;
   import rxscr_pkg::*;
   logic core_clk_in = 1'b0, reset_in = 1'b1;
   logic sen, sclk, hdat, sdo, oe_n, line;
   logic gain = 1'b0, auto_cap = 1'b0, rc_act = 1'b0, qdone = 1'b0;
   logic lband = 1'b0, trans = 1'b0;
   logic [1:0] sub_cmd = 2'h0;
   logic [3:0] cnt = 4'h0, rc_res = 4'h0;
   logic [6:0] qres = 7'h00, qval;
   logic qstart, qact, vco, pfd, fast, settled;
   logic [11:0] width;
   logic [4:0] code;
   logic [8:0] ua;
   logic [7:0] d;
   integer seed = 66;
   int n_errors = 0, n_checks = 0, n_start = 0;
   int m_synth = 'h04, m_qval = 0, m_qact = 0, g, c2, r;
   int q_synth[$];
   initial begin
      forever #50 core_clk_in = ~core_clk_in;
   end
   // the data pin as seen by both parties
   assign line = oe_n ? hdat : sdo;
   always @(posedge core_clk_in) if (qstart === 1'b1) n_start++;
   rxscr_regs i_rxscr_regs (
      .core_clk_in(core_clk_in), .reset_in(reset_in),
      .ser_enable_in(sen), .ser_clk_in(sclk), .ser_data_in(line),
      .ser_data_out(sdo), .ser_data_oe_n_out(oe_n),
      .rx_high_gain_in(gain), .rx_sub_cmd_in(sub_cmd),
      .transition_count_in(cnt), .auto_capture_in(auto_cap),
      .rc_filter_cal_active_in(rc_act), .rc_filter_cal_result_in(rc_res),
      .quadrature_cal_done_in(qdone), .quadrature_cal_result_in(qres),
      .lower_band_in(lband), .filter_transient_in(trans),
      .quadrature_cal_start_out(qstart), .quadrature_cal_active_out(qact),
      .quadrature_cal_value_out(qval), .low_oscillator_drive_out(vco),
      .long_detector_reset_pulse_out(pfd),
      .detector_reset_width_ps_out(width),
      .fast_filter_settling_out(fast), .filter_settled_out(settled),
      .charge_pump_current_code_out(code),
      .charge_pump_current_ua_out(ua));
   rxscr_host_model i_rxscr_host_model (
      .core_clk_in(core_clk_in), .line_in(line), .ser_enable_out(sen),
      .ser_clk_out(sclk), .ser_data_out(hdat));
   // ==========================================================
   // helpers
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   task automatic rd(input logic [6:0] a);
      i_rxscr_host_model.xfer(1'b1, a, 8'h00, d);
   endtask
   task automatic wr(input logic [6:0] a, input int v);
      i_rxscr_host_model.xfer(1'b0, a, 8'(v), d);
   endtask
   task automatic check_reg(input logic [6:0] a, input int exp);
      rd(a);
      n_checks++;
      if (d !== 8'(exp)) begin
         n_errors++;
         $display("[FAIL] %0t reg %h read %h exp %h", $time, a, d, 8'(exp));
      end
   endtask
   task automatic check_out(input string s, input logic [11:0] got,
                            input int exp);
      n_checks++;
      if (got !== 12'(exp)) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, s, got, 12'(exp));
      end
   endtask
   task automatic check_synth();
      check_reg(RXSCR_ADDR_SYNTH, m_synth);
      check_out("vco", 12'(vco), m_synth >> 7 & 1);
      check_out("pfd", 12'(pfd), m_synth >> 6 & 1);
      check_out("width", width, (m_synth >> 6 & 1) ? RXSCR_PFD_LONG_PS
                : RXSCR_PFD_SHORT_PS);
      check_out("fast", 12'(fast), m_synth >> 5 & 1);
      check_out("code", 12'(code), m_synth & 'h1F);
      check_out("ua", 12'(ua), (m_synth & 'h1F) * 15);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================================
   // watchdog
   initial begin
      #5000000;
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test();
   end
   // ==========================================================
   // tests
   initial begin
      step(12);
      reset_in = 1'b0;
      step(4);
      check_synth();
      check_out("settled", 12'(settled), 1);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         g = $random(seed) & 1;
         c2 = $random(seed) & 'hF;
         gain = g[0];
         sub_cmd = 2'(c);
         cnt = 4'(c2);
         // held high: automatic capture wins over the read capture
         auto_cap = (c == 3);
         rd(RXSCR_ADDR_SNAP);
         check_out("gain", 12'(d[7]), g);
         check_out("flag", 12'(d[6]), c != 3);
         check_out("cmd", 12'(d[5:4]), c);
         check_out("count", 12'(d[3:0]), c2);
      end
      auto_cap = 1'b0;
      $display("test snapshot done");
      m_qval = $random(seed) & 'h7F;
      wr(RXSCR_ADDR_QCAL, m_qval);
      check_out("start", 12'(n_start), 0);
      check_out("qval", 12'(qval), m_qval);
      wr(RXSCR_ADDR_QCAL, 'h80 | m_qval);
      m_qact = 1;
      check_out("start", 12'(n_start), 1);
      check_out("qact", 12'(qact), 1);
      for (int i = 0; i < 3; i++) begin
         rc_act = 1'(i);
         rc_res = 4'($random(seed));
         r = m_qact * 128 + i % 2 * 64 + rc_res;
         check_reg(RXSCR_ADDR_FCAL, r);
         qres = 7'($random(seed));
         qdone = (i == 1);
         step(1);
         qdone = 1'b0;
         if (i == 1) begin
            m_qact = 0;
            m_qval = qres;
         end
      end
      check_reg(RXSCR_ADDR_QCAL, m_qact * 128 + m_qval);
      check_out("qact", 12'(qact), 0);
      wr(RXSCR_ADDR_FCAL, 'hFF);
      check_reg(RXSCR_ADDR_FCAL, rc_act * 64 + rc_res);
      wr(7'h00, 'hFF);
      check_reg(7'h00, 0);
      $display("test calibration done");
      for (int i = 0; i < 6; i++) q_synth.push_back($random(seed) & 'hFF);
      while (q_synth.size() > 0) begin
         m_synth = q_synth.pop_front();
         wr(RXSCR_ADDR_SYNTH, m_synth);
         check_synth();
      end
      wr(RXSCR_ADDR_SYNTH, 'h00);
      lband = 1'b1;
      step(2);
      lband = 1'b0;
      m_synth = 'h80;
      check_synth();
      $display("test synth done");
      for (int f = 0; f < 2; f++) begin
         r = f ? RXSCR_SETTLE_SHORT : RXSCR_SETTLE_LONG;
         m_synth = f * 'h20 + 'h04;
         wr(RXSCR_ADDR_SYNTH, m_synth);
         trans = 1'b1;
         step(1);
         trans = 1'b0;
         step(r - 4);
         check_out("settle", 12'(settled), 0);
         step(8);
         check_out("settle", 12'(settled), 1);
      end
      $display("test settle done");
      finish_test();
   end
endmodule
